// ===== boost_regs_pkg.sv
// Shared constants, register layouts and state types of the converter register bank
package boost_regs_pkg;

    // Serial slave address, register pointers and the unmapped read value
    localparam logic [6:0] SLAVE_ADDR        = 7'h39;
    localparam logic [7:0] BOOST_CONFIG_ADDR = 8'h01;
    localparam logic [7:0] LIMIT_CTRL_ADDR   = 8'h03;
    localparam logic [7:0] OPTION_CTRL_ADDR  = 8'h04;
    localparam logic [7:0] UNMAPPED_READ     = 8'h00;

    // Reset values
    localparam logic [7:0] BOOST_CONFIG_RST  = 8'h1E;
    localparam logic [7:0] LIMIT_CTRL_RST    = 8'h90;
    localparam logic [7:0] OPTION_CTRL_RST   = 8'h0F;

    // Current decode constants in mA, plus the soft-start base code
    localparam logic [12:0] PRECHARGE_STEP_MA   = 13'h01F4;
    localparam logic [12:0] SOFTSTART_BASE_MA   = 13'h0BB8;
    localparam logic [12:0] SOFTSTART_STEP_MA   = 13'h01F4;
    localparam logic [3:0]  SOFTSTART_BASE_CODE = 4'h9;
    localparam logic [12:0] AVG_BASE_MA         = 13'h0C1C;
    localparam logic [12:0] AVG_STEP_MA         = 13'h00AA;

    // Timing: discharge hold after enable falls
    localparam int CLK_HZ            = 20_000_000;
    localparam int DISCHARGE_TIME_MS = 10;
    localparam int DISCHARGE_CYCLES  = DISCHARGE_TIME_MS * (CLK_HZ / 1000);

    // Register 0x01 layout, msb first
    typedef struct packed {
        logic       reserved_b7;
        logic       valley_limit_disable;
        logic [1:0] precharge_current_sel;
        logic [2:0] gate_drive_strength;
        logic       spread_spectrum_en;
    } boost_config_t;

    // Register 0x03 layout
    typedef struct packed {
        logic [3:0] softstart_valley_limit;
        logic [3:0] avg_out_limit_sel;
    } current_limit_t;

    // Register 0x04 layout
    typedef struct packed {
        logic [3:0] reserved_hi;
        logic [1:0] switch_freq_sel;
        logic       avg_limit_enable;
        logic       discharge_en;
    } option_t;

    // Decoded controls toward the power stage
    typedef struct packed {
        logic        valley_limit_on;
        logic [12:0] precharge_ma;
        logic [2:0]  gate_drive_strength;
        logic        spread_spectrum_on;
        logic [12:0] softstart_limit_ma;
        logic [12:0] avg_limit_ma;
        logic        avg_limit_on;
        logic [1:0]  switch_freq_sel;
        logic        discharge_en;
    } power_ctrl_t;

    // Serial slave protocol states
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ACK_A, S_RX, S_ACK_W, S_TX, S_RACK
    } slave_state_t;

    // Power-down sequence states
    typedef enum logic [1:0] {
        P_ACTIVE, P_DISCHARGE, P_OFF
    } power_state_t;

endpackage

// ===== power_down_seq.sv
// Output discharge and shutdown sequencer driven by the enable pin
`timescale 1ns/1ns
`default_nettype none
module power_down_seq #(
    parameter int HOLD_CYCLES = boost_regs_pkg::DISCHARGE_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Control
    input  wire logic en,
    input  wire logic discharge_en,
    // Power stage
    output logic      discharge_switch_on,
    output logic      full_shutdown
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    if (HOLD_CYCLES < 1) begin : g_chk
        $error("HOLD_CYCLES must be at least one");
    end

    typedef struct packed {
        boost_regs_pkg::power_state_t st;
        logic [CW-1:0]                cnt;
        logic                         dis;
        logic                         off;
    } seq_t;

    seq_t cur;
    seq_t next;

    // Sequence: run, discharge for the hold time, then shut down
    always_comb begin
        next = cur;
        case (cur.st)
            boost_regs_pkg::P_ACTIVE: begin
                if (!en) begin
                    if (discharge_en) begin
                        next.st  = boost_regs_pkg::P_DISCHARGE;
                        next.cnt = '0;
                        next.dis = 1'b1;
                    end else begin
                        next.st  = boost_regs_pkg::P_OFF;
                        next.off = 1'b1;
                    end
                end
            end
            boost_regs_pkg::P_DISCHARGE: begin
                if (en) begin
                    next.st  = boost_regs_pkg::P_ACTIVE;
                    next.dis = 1'b0;
                end else if (cur.cnt == CW'(HOLD_CYCLES - 1)) begin
                    next.st  = boost_regs_pkg::P_OFF;
                    next.dis = 1'b0;
                    next.off = 1'b1;
                end else begin
                    next.cnt = CW'(cur.cnt + 1'b1);
                end
            end
            boost_regs_pkg::P_OFF: begin
                if (en) begin
                    next.st  = boost_regs_pkg::P_ACTIVE;
                    next.off = 1'b0;
                end
            end
            default: begin
                next.st  = boost_regs_pkg::P_OFF;
                next.dis = 1'b0;
                next.off = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur.st  <= boost_regs_pkg::P_OFF;
            cur.cnt <= '0;
            cur.dis <= 1'b0;
            cur.off <= 1'b1;
        end else begin
            cur <= next;
        end
    end

    assign discharge_switch_on = cur.dis;
    assign full_shutdown       = cur.off;

endmodule // power_down_seq
`default_nettype wire

// ===== boost_config_regs.sv
// Two-wire serial register bank of the boost converter with decoded power-stage controls
`timescale 1ns/1ns
`default_nettype none
module boost_config_regs #(
    parameter int DISCHARGE_CYCLES = boost_regs_pkg::DISCHARGE_CYCLES
) (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // Two-wire serial bus
    input  wire logic                        scl,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe_n,
    // Enable pin
    input  wire logic                        en,
    // Power stage controls
    output boost_regs_pkg::power_ctrl_t      power_ctrl,
    output logic                             discharge_switch_on,
    output logic                             full_shutdown
);

    typedef struct packed {
        boost_regs_pkg::slave_state_t   st;
        logic [3:0]                     cnt;
        logic [7:0]                     shift;
        logic                           rw;
        logic                           ptr_phase;
        logic [7:0]                     ptr;
        logic                           scl_q;
        logic                           sda_q;
        logic                           oe_n;
        boost_regs_pkg::boost_config_t  cfg;
        boost_regs_pkg::current_limit_t lim;
        boost_regs_pkg::option_t        opt;
        boost_regs_pkg::power_ctrl_t    pwr;
    } bank_t;

    bank_t cur;
    bank_t next;

    // Register readback by pointer
    function automatic logic [7:0] reg_read(input logic [7:0] ptr, input bank_t s);
        case (ptr)
            boost_regs_pkg::BOOST_CONFIG_ADDR: reg_read = s.cfg;
            boost_regs_pkg::LIMIT_CTRL_ADDR:   reg_read = s.lim;
            boost_regs_pkg::OPTION_CTRL_ADDR:  reg_read = s.opt;
            default:                           reg_read = boost_regs_pkg::UNMAPPED_READ;
        endcase
    endfunction

    // Soft-start code to mA; codes below the base clamp to the base
    function automatic logic [12:0] softstart_ma(input logic [3:0] code);
        logic [3:0] steps;
        steps = (code > boost_regs_pkg::SOFTSTART_BASE_CODE) ?
                4'(code - boost_regs_pkg::SOFTSTART_BASE_CODE) : 4'h0;
        softstart_ma = 13'(boost_regs_pkg::SOFTSTART_BASE_MA +
                           13'(steps * boost_regs_pkg::SOFTSTART_STEP_MA));
    endfunction

    // Average limit code to mA
    function automatic logic [12:0] avg_ma(input logic [3:0] code);
        avg_ma = 13'(boost_regs_pkg::AVG_BASE_MA - 13'(code * boost_regs_pkg::AVG_STEP_MA));
    endfunction

    // Bus protocol, register writes and power-stage decode
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_cond;
        logic stop_cond;
        logic [7:0] rd;
        scl_rise   = scl & ~cur.scl_q;
        scl_fall   = ~scl & cur.scl_q;
        start_cond = scl & cur.scl_q & cur.sda_q & ~sda_in;
        stop_cond  = scl & cur.scl_q & ~cur.sda_q & sda_in;
        rd         = reg_read(cur.ptr, cur);
        next       = cur;
        next.scl_q = scl;
        next.sda_q = sda_in;
        if (start_cond) begin
            next.st   = boost_regs_pkg::S_ADDR;
            next.cnt  = 4'h0;
            next.oe_n = 1'b1;
        end else if (stop_cond) begin
            next.st   = boost_regs_pkg::S_IDLE;
            next.oe_n = 1'b1;
        end else begin
            case (cur.st)
                boost_regs_pkg::S_IDLE: begin
                    next.oe_n = 1'b1;
                end
                boost_regs_pkg::S_ADDR, boost_regs_pkg::S_RX: begin
                    if (scl_rise) begin
                        next.shift = {cur.shift[6:0], sda_in};
                        next.cnt   = 4'(cur.cnt + 1'b1);
                    end else if (scl_fall && cur.cnt == 4'h8) begin
                        if (cur.st == boost_regs_pkg::S_ADDR) begin
                            if (cur.shift[7:1] == boost_regs_pkg::SLAVE_ADDR) begin
                                next.rw   = cur.shift[0];
                                next.oe_n = 1'b0;
                                next.st   = boost_regs_pkg::S_ACK_A;
                            end else begin
                                next.st = boost_regs_pkg::S_IDLE;
                            end
                        end else begin
                            next.oe_n = 1'b0;
                            next.st   = boost_regs_pkg::S_ACK_W;
                            if (cur.ptr_phase) begin
                                next.ptr       = cur.shift;
                                next.ptr_phase = 1'b0;
                            end else begin
                                next.ptr = 8'(cur.ptr + 1'b1);
                                case (cur.ptr)
                                    boost_regs_pkg::BOOST_CONFIG_ADDR: next.cfg = cur.shift;
                                    boost_regs_pkg::LIMIT_CTRL_ADDR:   next.lim = cur.shift;
                                    boost_regs_pkg::OPTION_CTRL_ADDR:  next.opt = cur.shift;
                                    default:                           next.ptr = 8'(cur.ptr + 1'b1);
                                endcase
                            end
                        end
                    end
                end
                boost_regs_pkg::S_ACK_A, boost_regs_pkg::S_RACK: begin
                    if (scl_rise && cur.st == boost_regs_pkg::S_RACK && sda_in) begin
                        // Host declined further data
                        next.st = boost_regs_pkg::S_IDLE;
                    end else if (scl_fall) begin
                        if (cur.rw) begin
                            next.shift = rd;
                            next.ptr   = 8'(cur.ptr + 1'b1);
                            next.oe_n  = rd[7];
                            next.cnt   = 4'h1;
                            next.st    = boost_regs_pkg::S_TX;
                        end else begin
                            next.oe_n      = 1'b1;
                            next.cnt       = 4'h0;
                            next.ptr_phase = 1'b1;
                            next.st        = boost_regs_pkg::S_RX;
                        end
                    end
                end
                boost_regs_pkg::S_ACK_W: begin
                    if (scl_fall) begin
                        next.oe_n = 1'b1;
                        next.cnt  = 4'h0;
                        next.st   = boost_regs_pkg::S_RX;
                    end
                end
                boost_regs_pkg::S_TX: begin
                    if (scl_fall) begin
                        if (cur.cnt == 4'h8) begin
                            next.oe_n = 1'b1;
                            next.st   = boost_regs_pkg::S_RACK;
                        end else begin
                            next.oe_n  = cur.shift[6];
                            next.shift = {cur.shift[6:0], 1'b0};
                            next.cnt   = 4'(cur.cnt + 1'b1);
                        end
                    end
                end
                default: begin
                    next.st   = boost_regs_pkg::S_IDLE;
                    next.oe_n = 1'b1;
                end
            endcase
        end

        next.pwr.valley_limit_on     = ~cur.cfg.valley_limit_disable;
        next.pwr.precharge_ma        = 13'(13'({11'h000, cur.cfg.precharge_current_sel} + 13'h0001)
                                           * boost_regs_pkg::PRECHARGE_STEP_MA);
        next.pwr.gate_drive_strength = cur.cfg.gate_drive_strength;
        next.pwr.spread_spectrum_on  = cur.cfg.spread_spectrum_en;
        next.pwr.softstart_limit_ma  = softstart_ma(cur.lim.softstart_valley_limit);
        next.pwr.avg_limit_ma        = avg_ma(cur.lim.avg_out_limit_sel);
        next.pwr.avg_limit_on        = cur.opt.avg_limit_enable;
        next.pwr.switch_freq_sel     = cur.opt.switch_freq_sel;
        next.pwr.discharge_en        = cur.opt.discharge_en;
    end

    // State register; reset defaults
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur.st        <= boost_regs_pkg::S_IDLE;
            cur.cnt       <= 4'h0;
            cur.shift     <= 8'h00;
            cur.rw        <= 1'b0;
            cur.ptr_phase <= 1'b0;
            cur.ptr       <= 8'h00;
            cur.scl_q     <= 1'b1;
            cur.sda_q     <= 1'b1;
            cur.oe_n      <= 1'b1;
            cur.cfg       <= boost_regs_pkg::BOOST_CONFIG_RST;
            cur.lim       <= boost_regs_pkg::LIMIT_CTRL_RST;
            cur.opt       <= boost_regs_pkg::OPTION_CTRL_RST;
            cur.pwr       <= '0;
        end else begin
            cur <= next;
        end
    end

    // Open-drain data: only ever pulls low
    always_ff @(posedge sys_clk) begin
        sda_out <= 1'b0;
    end

    assign sda_oe_n   = cur.oe_n;
    assign power_ctrl = cur.pwr;

    power_down_seq #(
        .HOLD_CYCLES (DISCHARGE_CYCLES)
    ) u_power_down_seq (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .en                  (en),
        .discharge_en        (cur.opt.discharge_en),
        .discharge_switch_on (discharge_switch_on),
        .full_shutdown       (full_shutdown)
    );

endmodule // boost_config_regs
`default_nettype wire

// ===== i2c_host_model.sv
// Two-wire bus host model driving the register bank from the far side
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model #(
    parameter logic [6:0] ADDR = 7'h39,
    parameter int         Q    = 13
) (
    // Clock and device pull-down
    input  wire logic sys_clk,
    input  wire logic sda_oe_n,
    // Bus wires
    output logic      scl,
    output logic      sda_in
);
    logic drv;
    // Open-drain wire, pulled up when nobody pulls low
    assign sda_in = drv & sda_oe_n;
    initial begin
        scl = 1'h1;
        drv = 1'h1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Start and repeated start
    task automatic start;
        drv = 1'h1; tick(Q); scl = 1'h1; tick(Q); drv = 1'h0; tick(Q); scl = 1'h0; tick(Q);
    endtask
    task automatic stop;
        drv = 1'h0; tick(Q); scl = 1'h1; tick(Q); drv = 1'h1; tick(Q);
    endtask
    task automatic bitx(input logic b, output logic s);
        drv = b; tick(Q); scl = 1'h1; tick(Q); s = sda_in; tick(Q); scl = 1'h0; tick(Q);
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ak);
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(a, ak);
    endtask
    task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ack);
        logic [7:0] r;
        logic a0, a1, a2;
        start; xfer({a, 1'h0}, 1'h1, r, a0); xfer(p, 1'h1, r, a1); xfer(d, 1'h1, r, a2); stop;
        ack = a0 | a1 | a2;
    endtask
    task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
        logic [7:0] r;
        logic a;
        start; xfer({ADDR, 1'h0}, 1'h1, r, a); xfer(p, 1'h1, r, a);
        start; xfer({ADDR, 1'h1}, 1'h1, r, a); xfer(8'hFF, 1'h1, d, a); stop;
    endtask
endmodule // i2c_host_model
`default_nettype wire

// ===== boost_config_regs_checker.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
`default_nettype none
module boost_config_regs_checker #(
    parameter int DISCHARGE_CYCLES = boost_regs_pkg::DISCHARGE_CYCLES
) (
    // Clock, reset, bus, enable
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire logic                   scl,
    input wire logic                   sda_in,
    input wire logic                   sda_out,
    input wire logic                   sda_oe_n,
    input wire logic                   en,
    // Power stage
    input wire boost_regs_pkg::power_ctrl_t power_ctrl,
    input wire logic                   discharge_switch_on,
    input wire logic                   full_shutdown
);
    int         hold_cnt;
    logic [1:0] up;
    // Cycles since reset and length of the discharge hold
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            up <= 2'h0;
            hold_cnt <= 0;
        end else begin
            if (up != 2'h3) up <= up + 2'h1;
            hold_cnt <= discharge_switch_on ? hold_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_def;
        $fell(rst) |-> ##[1:2] (power_ctrl.avg_limit_ma == 13'h0C1C && power_ctrl.avg_limit_on && power_ctrl.discharge_en);
    endproperty
    a_def: assert property (p_def) else $error("reset defaults wrong");
    property p_prech;
        up == 2'h3 |-> power_ctrl.precharge_ma inside {13'h01F4, 13'h03E8, 13'h05DC, 13'h07D0};
    endproperty
    a_prech: assert property (p_prech) else $error("precharge value off grid");
    property p_soft;
        up == 2'h3 |-> power_ctrl.softstart_limit_ma inside {[13'h0BB8:13'h1770]}
            && (power_ctrl.softstart_limit_ma - 13'h0BB8) % 13'h01F4 == 13'h0000;
    endproperty
    a_soft: assert property (p_soft) else $error("softstart limit off grid");
    property p_avg;
        up == 2'h3 |-> power_ctrl.avg_limit_ma inside {[13'h0226:13'h0C1C]}
            && (13'h0C1C - power_ctrl.avg_limit_ma) % 13'h00AA == 13'h0000;
    endproperty
    a_avg: assert property (p_avg) else $error("average limit off grid");
    property p_dstart;
        $fell(en) && power_ctrl.discharge_en && !full_shutdown && !discharge_switch_on |=> discharge_switch_on && !full_shutdown;
    endproperty
    a_dstart: assert property (p_dstart) else $error("discharge did not start");
    property p_dhold;
        $fell(discharge_switch_on) && !en |-> hold_cnt == DISCHARGE_CYCLES && full_shutdown;
    endproperty
    a_dhold: assert property (p_dhold) else $error("discharge hold length wrong");
    property p_nodis;
        $fell(en) && !power_ctrl.discharge_en && !full_shutdown && !discharge_switch_on |=> full_shutdown && !discharge_switch_on;
    endproperty
    a_nodis: assert property (p_nodis) else $error("shutdown without discharge wrong");
    property p_enhigh;
        en && (full_shutdown || discharge_switch_on) |=> !full_shutdown && !discharge_switch_on;
    endproperty
    a_enhigh: assert property (p_enhigh) else $error("enable high did not wake");
    property p_sda;
        $changed(sda_oe_n) |-> !scl && sda_out == 1'h0;
    endproperty
    a_sda: assert property (p_sda) else $error("data changed while clock high");
    c_dis: cover property ($rose(discharge_switch_on));
    c_ack: cover property (!sda_oe_n ##1 sda_oe_n);
    c_off: cover property ($rose(full_shutdown));
endmodule // boost_config_regs_checker
bind boost_config_regs boost_config_regs_checker #(.DISCHARGE_CYCLES(DISCHARGE_CYCLES)) chk_inst (
    .sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .en(en), .power_ctrl(power_ctrl), .discharge_switch_on(discharge_switch_on), .full_shutdown(full_shutdown));
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench of the converter register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    localparam int HOLD = 20;
    logic sys_clk, rst, en, scl, sda_in, sda_out, sda_oe_n, discharge_switch_on, full_shutdown, ack;
    boost_regs_pkg::power_ctrl_t power_ctrl;
    logic [7:0] rd;
    int         n_errors = 0;
    int         check_count = 0;
    // Device and host
    boost_config_regs #(.DISCHARGE_CYCLES(HOLD)) boost_config_regs_inst (.sys_clk(sys_clk), .rst(rst),
        .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .en(en), .power_ctrl(power_ctrl),
        .discharge_switch_on(discharge_switch_on), .full_shutdown(full_shutdown));
    i2c_host_model i2c_host_model_inst (.sys_clk(sys_clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda_in(sda_in));
    task automatic close_out;
        if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        i2c_host_model_inst.write_reg(7'h39, p, d, ack);
        `CHK("ack", 1'h0, ack)
    endtask
    task automatic t_reset;
        i2c_host_model_inst.read_reg(8'h01, rd); `CHK("cfg", 8'h1E, rd)
        i2c_host_model_inst.read_reg(8'h03, rd); `CHK("lim", 8'h90, rd)
        i2c_host_model_inst.read_reg(8'h04, rd); `CHK("opt", 8'h0F, rd)
        `CHK("valley_on", 1'h1, power_ctrl.valley_limit_on)
        `CHK("prech", 13'h03E8, power_ctrl.precharge_ma)
        `CHK("drive", 3'h7, power_ctrl.gate_drive_strength)
        `CHK("ss", 1'h0, power_ctrl.spread_spectrum_on)
        `CHK("soft", 13'h0BB8, power_ctrl.softstart_limit_ma)
        `CHK("avg", 13'h0C1C, power_ctrl.avg_limit_ma)
        `CHK("avg_on", 1'h1, power_ctrl.avg_limit_on)
        `CHK("dis_en", 1'h1, power_ctrl.discharge_en)
    endtask
    // Every code of both limit fields
    task automatic t_limits;
        for (int k = 0; k < 16; k++) begin
            wr(8'h03, {4'(k), 4'(k)});
            tick(2);
            `CHK("soft", 13'(k < 9 ? 32'h0BB8 : 32'h01F4 * k - 32'h05DC), power_ctrl.softstart_limit_ma)
            `CHK("avg", 13'(32'h0C1C - 32'h00AA * k), power_ctrl.avg_limit_ma)
        end
        i2c_host_model_inst.read_reg(8'h03, rd); `CHK("lim", 8'hFF, rd)
    endtask
    task automatic t_config;
        for (int i = 0; i < 4; i++) begin
            wr(8'h01, {1'h0, i[0], i[1:0], 3'(i), i[0]});
            tick(2);
            `CHK("valley_on", ~i[0], power_ctrl.valley_limit_on)
            `CHK("prech", 13'(32'h01F4 * (i + 1)), power_ctrl.precharge_ma)
            `CHK("drive", 3'(i), power_ctrl.gate_drive_strength)
            `CHK("ss", i[0], power_ctrl.spread_spectrum_on)
        end
    endtask
    // Foreign address ignored, unmapped pointer reads zero
    task automatic t_refuse;
        i2c_host_model_inst.write_reg(7'h3A, 8'h04, 8'h00, ack);
        `CHK("nack", 1'h1, ack)
        i2c_host_model_inst.read_reg(8'h04, rd); `CHK("opt", 8'h0F, rd)
        i2c_host_model_inst.read_reg(8'h05, rd); `CHK("unmapped", 8'h00, rd)
    endtask
    task automatic t_discharge;
        int n;
        en = 1'h0;
        tick(1);
        `CHK("dis_on", 1'h1, discharge_switch_on)
        n = 0;
        while (full_shutdown !== 1'h1 && n < 100) begin
            tick(1);
            n++;
        end
        `CHK("hold", HOLD, n)
        `CHK("dis_off", 1'h0, discharge_switch_on)
        en = 1'h1;
        tick(2);
        `CHK("awake", 2'h0, {full_shutdown, discharge_switch_on})
        wr(8'h04, 8'h0C);
        `CHK("avg_on", 1'h0, power_ctrl.avg_limit_on)
        `CHK("dis_en", 1'h0, power_ctrl.discharge_en)
        `CHK("fsw", 2'h3, power_ctrl.switch_freq_sel)
        en = 1'h0;
        tick(2);
        `CHK("quick_off", 2'h2, {full_shutdown, discharge_switch_on})
        en = 1'h1;
        wr(8'h04, 8'h0F);
        en = 1'h0;
        tick(4);
        `CHK("dis_on", 1'h1, discharge_switch_on)
        en = 1'h1;
        tick(2);
        `CHK("abort", 2'h0, {full_shutdown, discharge_switch_on})
    endtask
    // Clock
    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Watchdog
    initial begin
        #4_000_000;
        n_errors++;
        close_out;
    end
    // Main sequence
    initial begin
        rst = 1'h1;
        en = 1'h1;
        tick(3);
        rst = 1'h0;
        tick(2);
        t_reset;
        t_limits;
        t_config;
        t_refuse;
        t_discharge;
        close_out;
    end
endmodule // tb_top
`default_nettype wire
